// ### rtl/simd_csr_defs.vh
`ifndef SIMD_CSR_DEFS_VH
`define SIMD_CSR_DEFS_VH
// ==========================================
// identification query result bits
`define ID_LEAF_FEATURES      32'h00000001
`define ID_BIT_SAVE_RESTORE   24
`define ID_BIT_VECTOR_GEN1    25
`define ID_BIT_VECTOR_GEN2    26
// ==========================================
// control registers
`define CR4_BIT_OS_SAVE       9
`define CR4_BIT_OS_FAULT      10
`define CR0_BIT_EMULATION     2
// ==========================================
// control/status layout and reset
`define CSR_RESET             32'h00001F80
`define CSR_MASK_NO_DAZ       32'h0000FFBF
`define CSR_MASK_WITH_DAZ     32'h0000FFFF
`define CSR_MASK_DEFAULT      32'h0000FFBF
`define CSR_BIT_DAZ           6
`define CSR_FLAGS_LSB         0
`define CSR_FLAGS_MSB         5
`define CSR_MASKS_LSB         7
`define CSR_MASKS_MSB         12
`define CSR_ROUND_LSB         13
`define CSR_ROUND_MSB         14
`define CSR_BIT_FTZ           15
// ==========================================
// save image layout, word indices of the 512-byte image
`define IMG_WORDS             128
`define IMG_WORD_CSR          6
`define IMG_WORD_MASK         7
`define IMG_WORD_VEC0         40
`define IMG_WORD_X87_LAST     39
`define VEC_COUNT             8
`define VEC_WIDTH             128
`endif

// ### rtl/csr_write_check.v
`timescale 1ns/1ps
`include "simd_csr_defs.vh"
module csr_write_check (
   input  wire [31:0] write_value,
   input  wire [31:0] writable_bit_mask,
   output wire        reserved_hit
);
   // ==========================================
   // reserved-bit check
   // a 1 on any bit the mask clears is a fault
   assign reserved_hit = |(write_value & ~writable_bit_mask);
endmodule

// ### rtl/vector_reg_file.v
`timescale 1ns/1ps
`include "simd_csr_defs.vh"
module vector_reg_file (
   input  wire         clock,
   input  wire         resetn,
   input  wire         write_en,
   input  wire [2:0]   write_index,
   input  wire [127:0] write_data,
   input  wire [2:0]   read_index,
   output reg  [127:0] read_data
);
   // ==========================================
   // eight registers, one generate entry each
   reg [127:0] vector_registers [0:7];
   genvar g;
   generate
      for (g = 0; g < `VEC_COUNT; g = g + 1) begin : entry
         // hardware reset clears to +0.0; soft init has no path here
         always @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               vector_registers[g] <= 128'h0;
            end else if (write_en && write_index == g) begin
               vector_registers[g] <= write_data;
            end
         end
      end
   endgenerate
   // registered read port
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         read_data <= 128'h0;
      end else begin
         read_data <= vector_registers[read_index];
      end
   end
endmodule

// ### rtl/simd_control_status_feature_logic.v
// What this block does
// - query leaf 1 reports vector generations
// - query leaf 1 bit 24 save/restore
// - control four bit 9 os save enable
// - control four bit 10 os fault enable
// - unsupported vector op gives invalid opcode
// - missing query op gives invalid opcode
// - save image word 7 (bytes 28-31) holds mask
// - zero mask means FFBF, no denormals-zero
// - nonzero mask bit 6 means denormals-zero
// - mask zeros reserved, ones supported
// - writing reserved one raises protection fault
// - reset masks all six exceptions
// - reset clears six sticky flags
// - reset rounding field is nearest
// - reset flush-to-zero is off
// - reset denormals-zero bit is zero
// - reset loads 1F80, init keeps state
// - reset clears eight vector registers
// - save/restore move vectors and csr
// - save/restore also carry x87 state
`timescale 1ns/1ps
`include "simd_csr_defs.vh"
module simd_control_status_feature_logic #(
   parameter         HAS_QUERY        = 1,
   parameter         HAS_VECTOR_GEN1  = 1,
   parameter         HAS_VECTOR_GEN2  = 1,
   parameter         HAS_SAVE_RESTORE = 1,
   parameter         HAS_DAZ          = 1,
   parameter         REPORT_ZERO_MASK = 0
) (
   input  wire         clock,
   input  wire         resetn,
   input  wire         init_pulse,
   // identification query
   input  wire         query_req,
   input  wire [31:0]  query_leaf,
   output reg          query_done,
   output reg  [31:0]  query_result,
   // control register moves
   input  wire         cr_write,
   input  wire         cr_select_four,
   input  wire [31:0]  cr_write_data,
   input  wire         cr_read,
   output reg  [31:0]  cr_read_data,
   // vector instruction issue
   input  wire         vec_issue,
   input  wire         vec_is_gen2,
   // control/status load and store
   input  wire         csr_load,
   input  wire [31:0]  csr_load_data,
   output reg  [31:0]  simd_float_control_status,
   // save/restore image port, one word a cycle
   input  wire         save_req,
   input  wire         restore_req,
   output reg          image_busy,
   output reg          image_wr,
   output reg  [6:0]   image_addr,
   output reg  [31:0]  image_wr_data,
   input  wire [31:0]  image_rd_data,
   // x87 state word exchange
   input  wire [31:0]  x87_word_in,
   output reg  [31:0]  x87_word_out,
   output reg          x87_word_wr,
   // faults
   output reg          invalid_opcode_fault,
   output reg          general_protection_fault
);
   // ==========================================
   // constants and state
   localparam [1:0] ST_IDLE    = 2'd0;
   localparam [1:0] ST_SAVE    = 2'd1;
   localparam [1:0] ST_RESTORE = 2'd2;
   localparam [1:0] ST_CHECK   = 2'd3;
   localparam [31:0] LEAF_ONE  = `ID_LEAF_FEATURES;
   localparam [31:0] MASK_IMPL = HAS_DAZ ? `CSR_MASK_WITH_DAZ : `CSR_MASK_NO_DAZ;
   reg  [1:0]   state;
   reg  [6:0]   word;
   reg  [31:0]  control_register_four;
   reg  [31:0]  control_register_zero;
   reg  [31:0]  restore_csr;
   reg  [127:0] vec_shift;
   reg  [1:0]   next_state;
   reg  [31:0]  next_image_wr_data;
   reg  [2:0]   vec_windex;
   wire [2:0]   vec_read_index;
   wire [6:0]   word_ahead;
   wire         load_taken;
   wire         vector_word;
   wire         last_word;
   wire         restore_csr_fault;
   wire         csr_reserved_hit;
   wire         restore_reserved_hit;
   wire [127:0] vec_read;
   wire [2:0]   vec_index;
   reg          vec_we;
   reg  [127:0] vec_wdata;
   wire [31:0]  writable_bit_mask;
   wire [31:0]  saved_mask_field;
   wire [31:0]  feature_word;
   // effective mask; zero field stands for the default
   assign writable_bit_mask = MASK_IMPL;
   assign saved_mask_field  = REPORT_ZERO_MASK && !HAS_DAZ ? 32'h00000000 : MASK_IMPL;
   // feature word of leaf one
   assign feature_word = ((HAS_SAVE_RESTORE ? 32'h00000001 : 32'h00000000) << `ID_BIT_SAVE_RESTORE)
                       | ((HAS_VECTOR_GEN1 ? 32'h00000001 : 32'h00000000) << `ID_BIT_VECTOR_GEN1)
                       | ((HAS_VECTOR_GEN2 ? 32'h00000001 : 32'h00000000) << `ID_BIT_VECTOR_GEN2);
   assign vec_index = word[4:2] - 3'd2;
   // the read port is registered, so it is fed the index of the next word
   assign word_ahead        = word + 7'd1;
   assign vec_read_index    = word_ahead[4:2] - 3'd2;
   assign load_taken        = state == ST_IDLE && csr_load;
   assign vector_word       = word >= `IMG_WORD_VEC0 && word < `IMG_WORD_VEC0 + 4 * `VEC_COUNT;
   assign last_word         = word == `IMG_WORDS - 1;
   assign restore_csr_fault = state == ST_RESTORE && word == `IMG_WORD_CSR && restore_reserved_hit;
   // ==========================================
   // write checkers for the two csr write paths
   csr_write_check load_check (
      .write_value       (csr_load_data),
      .writable_bit_mask (writable_bit_mask),
      .reserved_hit      (csr_reserved_hit)
   );
   csr_write_check restore_check (
      .write_value       (image_rd_data),
      .writable_bit_mask (writable_bit_mask),
      .reserved_hit      (restore_reserved_hit)
   );
   vector_reg_file vregs (
      .clock       (clock),
      .resetn      (resetn),
      .write_en    (vec_we),
      .write_index (vec_windex),
      .write_data  (vec_wdata),
      .read_index  (vec_read_index),
      .read_data   (vec_read)
   );
   // ==========================================
   // identification query
   // one cycle answer; the result holds until the next query
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         query_done   <= 1'b0;
         query_result <= 32'h00000000;
      end else begin
         query_done <= query_req && HAS_QUERY != 0;
         if (query_req && HAS_QUERY != 0) begin
            query_result <= (query_leaf == LEAF_ONE) ? feature_word : 32'h00000000;
         end
      end
   end
   // ==========================================
   // invalid opcode fault
   // a part built without the query op faults on it instead of answering
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         invalid_opcode_fault <= 1'b0;
      end else begin
         invalid_opcode_fault <= (query_req && HAS_QUERY == 0)
                              || (vec_issue && (vec_is_gen2 ? HAS_VECTOR_GEN2 == 0 : HAS_VECTOR_GEN1 == 0));
      end
   end
   // ==========================================
   // control registers, written by software only
   // the os flags are plain storage: nothing in hardware sets them
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         control_register_four <= 32'h00000000;
         control_register_zero <= 32'h00000000;
         cr_read_data          <= 32'h00000000;
      end else begin
         if (cr_write && cr_select_four) begin
            control_register_four <= cr_write_data;
         end
         if (cr_write && !cr_select_four) begin
            control_register_zero <= cr_write_data;
         end
         if (cr_read) begin
            cr_read_data <= cr_select_four ? control_register_four : control_register_zero;
         end
      end
   end
   // ==========================================
   // sequencer next state
   // csr_load wins over save and restore; both are taken in idle only
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (csr_load) begin
               next_state = ST_IDLE;
            end else if (save_req) begin
               next_state = ST_SAVE;
            end else if (restore_req) begin
               next_state = ST_RESTORE;
            end
         end
         ST_SAVE: begin
            if (last_word) begin
               next_state = ST_IDLE;
            end
         end
         ST_RESTORE: begin
            if (restore_csr_fault) begin
               next_state = ST_IDLE;
            end else if (last_word) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end
   // ==========================================
   // state and image word counter
   // the counter only runs inside a transfer, so each one starts at word 0
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         word  <= 7'd0;
      end else begin
         state <= next_state;
         if (state == ST_SAVE || state == ST_RESTORE) begin
            word <= word + 7'd1;
         end else begin
            word <= 7'd0;
         end
      end
   end
   // ==========================================
   // busy flag
   // drops one cycle after idle is reached, once the last image write stands
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         image_busy <= 1'b0;
      end else begin
         image_busy <= state != ST_IDLE || next_state != ST_IDLE;
      end
   end
   // ==========================================
   // control/status register
   // init_pulse is deliberately not decoded: soft init keeps this state
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         simd_float_control_status <= `CSR_RESET;
      end else if (load_taken && !csr_reserved_hit) begin
         simd_float_control_status <= csr_load_data;
      end else if (state == ST_CHECK) begin
         simd_float_control_status <= restore_csr;
      end
   end
   // ==========================================
   // protection fault
   // a refused write never reaches the register, so it stays as it was
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         general_protection_fault <= 1'b0;
      end else begin
         general_protection_fault <= (load_taken && csr_reserved_hit) || restore_csr_fault;
      end
   end
   // ==========================================
   // save image word select
   // vector words use the read port, which fetched this word's register a cycle ago
   always @* begin
      next_image_wr_data = 32'h00000000;
      if (word == `IMG_WORD_CSR) begin
         next_image_wr_data = simd_float_control_status;
      end else if (word == `IMG_WORD_MASK) begin
         next_image_wr_data = saved_mask_field;
      end else if (word <= `IMG_WORD_X87_LAST) begin
         next_image_wr_data = x87_word_in;
      end else if (vector_word) begin
         case (word[1:0])
            2'd0: begin
               next_image_wr_data = vec_read[31:0];
            end
            2'd1: begin
               next_image_wr_data = vec_read[63:32];
            end
            2'd2: begin
               next_image_wr_data = vec_read[95:64];
            end
            default: begin
               next_image_wr_data = vec_read[127:96];
            end
         endcase
      end
   end
   // ==========================================
   // image port
   // one word a cycle; on restore the address runs a word ahead of the data
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         image_wr      <= 1'b0;
         image_addr    <= 7'd0;
         image_wr_data <= 32'h00000000;
      end else begin
         image_wr <= state == ST_SAVE;
         if (state == ST_SAVE) begin
            image_addr    <= word;
            image_wr_data <= next_image_wr_data;
         end else if (state == ST_RESTORE) begin
            image_addr <= word_ahead;
         end else begin
            image_addr <= 7'd0;
         end
      end
   end
   // ==========================================
   // restore gather: csr word held back, vectors four words at a time
   // the csr is committed last so a fault leaves it untouched
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         restore_csr <= 32'h00000000;
         vec_shift   <= 128'h0;
         vec_we      <= 1'b0;
         vec_wdata   <= 128'h0;
         vec_windex  <= 3'd0;
      end else begin
         vec_we <= 1'b0;
         if (state == ST_RESTORE && word == `IMG_WORD_CSR) begin
            restore_csr <= image_rd_data;
         end
         if (state == ST_RESTORE && vector_word) begin
            vec_shift <= {image_rd_data, vec_shift[127:32]};
            if (word[1:0] == 2'd3) begin
               vec_we     <= 1'b1;
               vec_wdata  <= {image_rd_data, vec_shift[127:32]};
               vec_windex <= vec_index; // held, the word count moves on before the write
            end
         end
      end
   end
   // ==========================================
   // x87 words handed back on restore
   // the mask word is not state, so it is read but never written back
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         x87_word_out <= 32'h00000000;
         x87_word_wr  <= 1'b0;
      end else begin
         x87_word_wr <= 1'b0;
         if (state == ST_RESTORE && word <= `IMG_WORD_X87_LAST && word != `IMG_WORD_CSR) begin
            x87_word_out <= image_rd_data;
            x87_word_wr  <= word != `IMG_WORD_MASK;
         end
      end
   end
endmodule

// ### dv/simd_csr_checker_asserts.sv
`timescale 1ns/1ps
// ==========================================
// port relations of the control/status block
module simd_csr_checker #(
   parameter HAS_QUERY        = 1,
   parameter HAS_VECTOR_GEN1  = 1,
   parameter HAS_VECTOR_GEN2  = 1,
   parameter HAS_SAVE_RESTORE = 1,
   parameter HAS_DAZ          = 1,
   parameter REPORT_ZERO_MASK = 0
) (
   input wire        clock,
   input wire        resetn,
   input wire        query_req,
   input wire [31:0] query_leaf,
   input wire        query_done,
   input wire [31:0] query_result,
   input wire        vec_issue,
   input wire        vec_is_gen2,
   input wire        csr_load,
   input wire [31:0] csr_load_data,
   input wire [31:0] simd_float_control_status,
   input wire        save_req,
   input wire        image_busy,
   input wire        image_wr,
   input wire [6:0]  image_addr,
   input wire [31:0] image_wr_data,
   input wire        invalid_opcode_fault,
   input wire        general_protection_fault
);
   // effective mask for fault checks, saved mask as the image reports it
   localparam [31:0] EFF   = HAS_DAZ ? 32'h0000FFFF : 32'h0000FFBF;
   localparam [31:0] SAVED = HAS_DAZ ? 32'h0000FFFF : (REPORT_ZERO_MASK ? 32'h00000000 : 32'h0000FFBF);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_reset_csr_value: assert property ($rose(resetn) |-> simd_float_control_status == 32'h00001F80)
      else $error("csr not at reset value after reset");
   a_query_leaf_one: assert property (query_req && query_leaf == 32'h00000001 && HAS_QUERY != 0 |=>
      query_done && query_result[26:24] == {HAS_VECTOR_GEN2 != 0, HAS_VECTOR_GEN1 != 0, HAS_SAVE_RESTORE != 0})
      else $error("feature bits wrong in query result");
   a_query_missing: assert property (query_req && HAS_QUERY == 0 |=> invalid_opcode_fault && !query_done)
      else $error("missing query did not fault");
   a_vector_fault: assert property (vec_issue |=>
      invalid_opcode_fault == ($past(vec_is_gen2) ? HAS_VECTOR_GEN2 == 0 : HAS_VECTOR_GEN1 == 0))
      else $error("vector fault does not match support");
   a_reserved_fault: assert property (csr_load && !image_busy && (csr_load_data & ~EFF) != 0 |=>
      general_protection_fault && $stable(simd_float_control_status))
      else $error("reserved write not refused");
   a_load_accept: assert property (csr_load && !image_busy && (csr_load_data & ~EFF) == 0 |=>
      !general_protection_fault && simd_float_control_status == $past(csr_load_data))
      else $error("legal load not taken");
   a_save_walk: assert property (save_req && !image_busy && !csr_load |=> image_busy ##1
      (image_wr && image_addr == 7'd0) ##127 (image_wr && image_addr == 7'd127) ##1 !image_busy)
      else $error("save image walk wrong");
   a_mask_word: assert property (image_wr && image_addr == 7'd7 |-> image_wr_data == SAVED)
      else $error("mask word wrong");
   a_csr_word: assert property (image_wr && image_addr == 7'd6 |-> image_wr_data == simd_float_control_status)
      else $error("csr word wrong");
endmodule
bind simd_control_status_feature_logic simd_csr_checker #(.HAS_QUERY(HAS_QUERY), .HAS_VECTOR_GEN1(HAS_VECTOR_GEN1),
   .HAS_VECTOR_GEN2(HAS_VECTOR_GEN2), .HAS_SAVE_RESTORE(HAS_SAVE_RESTORE), .HAS_DAZ(HAS_DAZ),
   .REPORT_ZERO_MASK(REPORT_ZERO_MASK)) checker_i (.clock(clock), .resetn(resetn), .query_req(query_req),
   .query_leaf(query_leaf), .query_done(query_done), .query_result(query_result), .vec_issue(vec_issue),
   .vec_is_gen2(vec_is_gen2), .csr_load(csr_load), .csr_load_data(csr_load_data),
   .simd_float_control_status(simd_float_control_status), .save_req(save_req), .image_busy(image_busy),
   .image_wr(image_wr), .image_addr(image_addr), .image_wr_data(image_wr_data),
   .invalid_opcode_fault(invalid_opcode_fault), .general_protection_fault(general_protection_fault));

// ### dv/simd_control_status_feature_logic_tb.sv
`timescale 1ns/1ps
module simd_control_status_feature_logic_tb;
   // ==========================================
   // stimulus and observed signals
   reg         clock, resetn, init_pulse, query_req, cr_write, cr_select_four, cr_read;
   reg         vec_issue, vec_is_gen2, csr_load, save_req, restore_req;
   reg  [31:0] query_leaf, cr_write_data, csr_load_data, image_rd_data, x87_word_in;
   wire [31:0] query_result, cr_read_data, csr, wdata, csr2, wdata2;
   wire [6:0]  addr, addr2;
   wire        busy, wr, wr2, iof, iof2, gp, gp2;
   reg  [31:0] img1 [0:127];
   reg  [31:0] img2 [0:127];
   reg  [31:0] mem  [0:127];
   reg         iof_s, iof2_s, gp_s, gp2_s;
   integer     err_total, num_checks, gp_cnt, gp_base, i;
   // full-featured part
   simd_control_status_feature_logic simd_control_status_feature_logic_i (.clock(clock), .resetn(resetn),
      .init_pulse(init_pulse), .query_req(query_req), .query_leaf(query_leaf), .query_done(),
      .query_result(query_result), .cr_write(cr_write), .cr_select_four(cr_select_four), .cr_write_data(cr_write_data),
      .cr_read(cr_read), .cr_read_data(cr_read_data), .vec_issue(vec_issue), .vec_is_gen2(vec_is_gen2),
      .csr_load(csr_load), .csr_load_data(csr_load_data), .simd_float_control_status(csr), .save_req(save_req),
      .restore_req(restore_req), .image_busy(busy), .image_wr(wr), .image_addr(addr), .image_wr_data(wdata),
      .image_rd_data(image_rd_data), .x87_word_in(x87_word_in), .x87_word_out(), .x87_word_wr(),
      .invalid_opcode_fault(iof), .general_protection_fault(gp));
   // reduced part: no query, no second generation, no denormals-zero, zero mask reported
   simd_control_status_feature_logic #(.HAS_QUERY(0), .HAS_VECTOR_GEN2(0), .HAS_DAZ(0), .REPORT_ZERO_MASK(1))
      simd_control_status_feature_logic_i2 (.clock(clock), .resetn(resetn), .init_pulse(init_pulse),
      .query_req(query_req), .query_leaf(query_leaf), .query_done(), .query_result(), .cr_write(cr_write),
      .cr_select_four(cr_select_four), .cr_write_data(cr_write_data), .cr_read(cr_read), .cr_read_data(),
      .vec_issue(vec_issue), .vec_is_gen2(vec_is_gen2), .csr_load(csr_load), .csr_load_data(csr_load_data),
      .simd_float_control_status(csr2), .save_req(save_req), .restore_req(restore_req), .image_busy(),
      .image_wr(wr2), .image_addr(addr2), .image_wr_data(wdata2), .image_rd_data(image_rd_data),
      .x87_word_in(x87_word_in), .x87_word_out(), .x87_word_wr(), .invalid_opcode_fault(iof2),
      .general_protection_fault(gp2));
   // ==========================================
   // clock, image memory and watchdog
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // capture save words; protection faults are pulses, so count them
   always @(posedge clock) begin
      if (wr) img1[addr] <= wdata;
      if (wr2) img2[addr2] <= wdata2;
      gp_cnt <= resetn ? gp_cnt + gp : 0;
   end
   // read data stands by the rising edge after the address
   always @(negedge clock) image_rd_data = mem[addr];
   // whole run is near 430 cycles, so 4000 leaves plenty of slack
   initial begin
      #20000;
      err_total = err_total + 1;
      tally_and_finish;
   end
   // ==========================================
   // tasks
   task chk(input [31:0] got, input [31:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one strobe per call: 0 init, 1 query, 2 cr write, 3 cr read, 4 vector, 5 load, 6 save, 7 restore
   task op(input integer k, input [31:0] d);
      @(negedge clock);
      {init_pulse, query_req, cr_write, cr_read, vec_issue, csr_load, save_req, restore_req} = 8'h80 >> k;
      query_leaf = d;
      cr_write_data = d;
      csr_load_data = d;
      @(negedge clock);
      {init_pulse, query_req, cr_write, cr_read, vec_issue, csr_load, save_req, restore_req} = 8'h00;
      // fault pulses stand only for this cycle, so catch them here
      {iof_s, iof2_s, gp_s, gp2_s} = {iof, iof2, gp, gp2};
      @(posedge clock);
      #1;
      for (i = 0; i < 200 && busy; i = i + 1) begin
         @(posedge clock);
         #1;
      end
      if (busy) begin
         err_total = err_total + 1;
         $display("Error at %0t: transfer never ended", $time);
      end
   endtask
   task tally_and_finish;
      if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      {resetn, init_pulse, query_req, cr_write, cr_select_four, cr_read, vec_issue, vec_is_gen2} = 8'h00;
      {csr_load, save_req, restore_req, query_leaf, cr_write_data, csr_load_data} = 0;
      {err_total, num_checks} = 0;
      x87_word_in = 32'hA5A55A5A;
      for (i = 0; i < 128; i = i + 1) mem[i] = 32'hC0DE0000 + i;
      mem[6] = 32'h00009F80;
      repeat (5) @(posedge clock);
      @(negedge clock) resetn = 1'b1;
      @(posedge clock) #1;
      chk(csr, 32'h00001F80);
      op(1, 32'h00000001);
      chk(query_result & 32'h07000000, 32'h07000000);
      chk(iof2_s, 1);
      @(negedge clock) cr_select_four = 1'b1;
      op(2, 32'h00000600);
      op(3, 0);
      chk(cr_read_data, 32'h00000600);
      @(negedge clock) cr_select_four = 1'b0;
      op(3, 0);
      chk(cr_read_data & 32'h00000004, 0);
      op(4, 0);
      chk({iof_s, iof2_s}, 0);
      @(negedge clock) vec_is_gen2 = 1'b1;
      op(4, 0);
      chk({iof_s, iof2_s}, 1);
      op(5, 32'h0000FFC0);
      chk(csr, 32'h0000FFC0);
      chk(gp2_s, 1);
      chk(csr2, 32'h00001F80);
      op(5, 32'h00010000);
      chk(gp_s, 1);
      chk(csr, 32'h0000FFC0);
      op(0, 0);
      chk(csr, 32'h0000FFC0);
      op(6, 0);
      chk(img1[6], 32'h0000FFC0);
      chk(img1[7], 32'h0000FFFF);
      chk(img2[7], 0);
      chk(img1[0], 32'hA5A55A5A);
      for (i = 40; i < 72; i = i + 1) chk(img1[i], 0);
      op(7, 0);
      chk(csr, 32'h00009F80);
      op(6, 0);
      for (i = 40; i < 72; i = i + 1) chk(img1[i], mem[i]);
      mem[6] = 32'h80000000;
      gp_base = gp_cnt;
      op(7, 0);
      chk(gp_cnt - gp_base, 1);
      chk(csr, 32'h00009F80);
      tally_and_finish;
   end
endmodule
